// [include/pwmps_pkg.sv]
// Constants shared by the pulse timer period register slice
package pwmps_pkg;

  // --------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------------
  localparam logic [15:0] IDX_CH0_PERIOD_LOW = 16'hF0A0;
  localparam logic [15:0] IDX_CH0_PERIOD_HIGH = 16'hF0A1;
  localparam logic [15:0] IDX_CH1_PERIOD_LOW = 16'hF0A8;
  localparam logic [15:0] IDX_CH1_PERIOD_HIGH = 16'hF0A9;
  localparam logic [15:0] IDX_CH2_DUTY_HIGH = 16'hF0B3;
  localparam logic [15:0] IDX_CH2_COUNTER_LOW = 16'hF0B4;
  localparam logic [15:0] IDX_CH2_COUNTER_HIGH = 16'hF0B5;
  localparam logic [15:0] IDX_CH2_CONTROL_ZERO = 16'hF0B6;
  localparam logic [15:0] IDX_CH2_CONTROL_ONE = 16'hF0B7;
  localparam logic [15:0] IDX_RUN_CONTROL = 16'hF0BF;

  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] PERIOD_BYTE_RESET = 8'hFF;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [7:0] DUTY_HIGH_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [7:0] CONTROL_ZERO_RESET = 8'h00;
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h40;
  localparam logic [2:0] RUN_RESET = 3'h0;

  // --------------------------------------------------------------------
  // Period values
  // --------------------------------------------------------------------
  localparam logic [15:0] PERIOD_ZERO = 16'h0000;
  localparam logic [15:0] PERIOD_SUBSTITUTE = 16'h0001;
  localparam logic [15:0] CH2_PERIOD_FULL = 16'hFFFF;

  // --------------------------------------------------------------------
  // Bus lanes and layout
  // --------------------------------------------------------------------
  localparam logic [3:0] STRB_NONE = 4'h0;
  localparam logic [3:0] STRB_BYTE = 4'h1;
  localparam logic [3:0] STRB_WORD = 4'h3;
  localparam int INDEX_LSB = 2;
  localparam int INDEX_MSB = 17;
  localparam int MIN_ADDR_WIDTH = 18;
  localparam int CHANNELS = 3;
  localparam int RUN_WIDTH = 3;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // --------------------------------------------------------------------
  // Bus slave states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } pwmps_bus_state_type;

endpackage

// [logic/pwmps_channel.sv]
// One channel: period buffer with zero substitution and running counter
`timescale 1ns/1ps
module pwmps_channel
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic run,
  input wire logic clear,
  input wire logic [15:0] period_value,
  output logic [15:0] count,
  output logic [15:0] period_buffer,
  output logic period_end
);

  logic [15:0] next_buffer;
  logic [16:0] count_plus;
  logic wrap;

  // --------------------------------------------------------------------
  // Period buffer
  // --------------------------------------------------------------------
  always_comb
  begin
    if (period_value == pwmps_pkg::PERIOD_ZERO)
      next_buffer = pwmps_pkg::PERIOD_SUBSTITUTE;
    else
      next_buffer = period_value;
  end

  assign count_plus = {1'b0, count} + 17'h00001;
  assign wrap = (count_plus >= {1'b0, period_buffer});

  // Follows the registers while stopped, reloads at each period end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      period_buffer <= pwmps_pkg::PERIOD_RESET;
    else if (!run || (tick && wrap))
      period_buffer <= next_buffer;
  end

  // --------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= pwmps_pkg::COUNTER_RESET;
    else if (clear)
      count <= pwmps_pkg::COUNTER_RESET;
    else if (run && tick)
    begin
      if (wrap)
        count <= pwmps_pkg::COUNTER_RESET;
      else
        count <= count_plus[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      period_end <= 1'b0;
    else
      period_end <= run && tick && wrap && !clear;
  end

endmodule

// [logic/pwmps_slice.sv]
// Period register slice of the three channel pulse timer, APB slave
`timescale 1ns/1ps
// Functional notes
// - Channel 0 period is 16 bits: low byte, high byte at next address.
// - Channel 1 period is 16 bits: low byte, high byte at next address.
// - Period low accepts byte or word access; period high only bytes.
// - All channel 0 and 1 period bytes reset to all ones.
// - Channel 0 period of zero loads one into its period buffer.
// - Channel 1 period of zero loads one into its period buffer.
// - Channel 2 counter: word-capable low byte, byte-only high; reset zero.
// - Channel 2 control zero: read-write, byte or word, resets zero.
// - Channel 2 control one: read-write, byte only, resets with bit 6.
// - Channel 2 duty high byte: read-write, byte only, resets zero.
// - Any accepted write to a counter byte clears the whole counter.
module pwmps_slice
#(
  parameter int ADDR_WIDTH = 18,
  parameter int TICK_DIVIDE = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] ch0_period_buffer,
  output logic [15:0] ch1_period_buffer,
  output logic [15:0] ch0_count,
  output logic [15:0] ch1_count,
  output logic [15:0] ch2_count,
  output logic [2:0] period_end,
  output logic [7:0] ch2_duty_high,
  output logic [7:0] ch2_control_zero,
  output logic [7:0] ch2_control_one
);

  // --------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------
  if (ADDR_WIDTH < pwmps_pkg::MIN_ADDR_WIDTH)
  begin : bad_addr_width
    $error("ADDR_WIDTH too small for the register map");
  end
  if (TICK_DIVIDE < 1 || TICK_DIVIDE > 65535)
  begin : bad_tick_divide
    $error("TICK_DIVIDE must lie between 1 and 65535");
  end

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  pwmps_pkg::pwmps_bus_state_type state;
  pwmps_pkg::pwmps_bus_state_type next_state;
  logic [7:0] ch0_period_low;
  logic [7:0] ch0_period_high;
  logic [7:0] ch1_period_low;
  logic [7:0] ch1_period_high;
  logic [2:0] run_control;
  logic [15:0] index;
  logic upper_zero;
  logic mapped;
  logic word_capable;
  logic strobe_legal;
  logic bad;
  logic error_latched;
  logic [31:0] read_value;
  logic write_go;
  logic word_write;
  logic low_lane;
  logic high_lane;
  logic [15:0] tick_count;
  logic tick;
  logic [15:0] period_value [pwmps_pkg::CHANNELS];
  logic [15:0] count_value [pwmps_pkg::CHANNELS];
  logic [15:0] buffer_value [pwmps_pkg::CHANNELS];
  logic [2:0] clear;
  logic ch2_clear;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  assign index = paddr[pwmps_pkg::INDEX_MSB:pwmps_pkg::INDEX_LSB];
  assign upper_zero = ((paddr >> pwmps_pkg::MIN_ADDR_WIDTH) == '0);

  always_comb
  begin
    mapped = 1'b1;
    word_capable = 1'b0;
    read_value = 32'h00000000;
    unique case (index)
      pwmps_pkg::IDX_CH0_PERIOD_LOW:
      begin
        word_capable = 1'b1;
        read_value = {16'h0000, ch0_period_high, ch0_period_low};
      end
      pwmps_pkg::IDX_CH0_PERIOD_HIGH:
        read_value = {24'h000000, ch0_period_high};
      pwmps_pkg::IDX_CH1_PERIOD_LOW:
      begin
        word_capable = 1'b1;
        read_value = {16'h0000, ch1_period_high, ch1_period_low};
      end
      pwmps_pkg::IDX_CH1_PERIOD_HIGH:
        read_value = {24'h000000, ch1_period_high};
      pwmps_pkg::IDX_CH2_DUTY_HIGH:
        read_value = {24'h000000, ch2_duty_high};
      pwmps_pkg::IDX_CH2_COUNTER_LOW:
      begin
        word_capable = 1'b1;
        read_value = {16'h0000, ch2_count};
      end
      pwmps_pkg::IDX_CH2_COUNTER_HIGH:
        read_value = {24'h000000, ch2_count[15:8]};
      pwmps_pkg::IDX_CH2_CONTROL_ZERO:
      begin
        word_capable = 1'b1;
        read_value = {16'h0000, ch2_control_one, ch2_control_zero};
      end
      pwmps_pkg::IDX_CH2_CONTROL_ONE:
        read_value = {24'h000000, ch2_control_one};
      pwmps_pkg::IDX_RUN_CONTROL:
        read_value = {29'h00000000, run_control};
      default:
        mapped = 1'b0;
    endcase
  end

  // Byte-only registers refuse a two-lane strobe
  always_comb
  begin
    strobe_legal = 1'b0;
    if (!pwrite)
      strobe_legal = 1'b1;
    else if (pstrb == pwmps_pkg::STRB_NONE || pstrb == pwmps_pkg::STRB_BYTE)
      strobe_legal = 1'b1;
    else if (pstrb == pwmps_pkg::STRB_WORD && word_capable)
      strobe_legal = 1'b1;
  end

  assign bad = !mapped || !upper_zero || !strobe_legal ||
    (paddr[1:0] != pwmps_pkg::WORD_ALIGN);

  // --------------------------------------------------------------------
  // Bus slave: setup latches the answer, access completes at once
  // --------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      pwmps_pkg::ST_IDLE:
        if (psel && !penable)
          next_state = pwmps_pkg::ST_ANSWER;
      pwmps_pkg::ST_ANSWER:
        next_state = pwmps_pkg::ST_IDLE;
      default:
        next_state = pwmps_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= pwmps_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      error_latched <= 1'b0;
    end
    else if (state == pwmps_pkg::ST_IDLE && psel && !penable)
    begin
      error_latched <= bad;
      if (!pwrite && !bad)
        prdata <= read_value;
      else
        prdata <= 32'h00000000;
    end
  end

  assign pready = (state == pwmps_pkg::ST_ANSWER);
  assign pslverr = pready && error_latched;

  assign write_go = pready && psel && penable && pwrite && !error_latched;
  assign word_write = (pstrb == pwmps_pkg::STRB_WORD);
  assign low_lane = write_go && pstrb[0];
  assign high_lane = write_go && word_write;

  // --------------------------------------------------------------------
  // Period registers
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch0_period_low <= pwmps_pkg::PERIOD_BYTE_RESET;
      ch0_period_high <= pwmps_pkg::PERIOD_BYTE_RESET;
    end
    else if (index == pwmps_pkg::IDX_CH0_PERIOD_LOW && low_lane)
    begin
      ch0_period_low <= pwdata[7:0];
      if (high_lane)
        ch0_period_high <= pwdata[15:8];
    end
    else if (index == pwmps_pkg::IDX_CH0_PERIOD_HIGH && low_lane)
      ch0_period_high <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch1_period_low <= pwmps_pkg::PERIOD_BYTE_RESET;
      ch1_period_high <= pwmps_pkg::PERIOD_BYTE_RESET;
    end
    else if (index == pwmps_pkg::IDX_CH1_PERIOD_LOW && low_lane)
    begin
      ch1_period_low <= pwdata[7:0];
      if (high_lane)
        ch1_period_high <= pwdata[15:8];
    end
    else if (index == pwmps_pkg::IDX_CH1_PERIOD_HIGH && low_lane)
      ch1_period_high <= pwdata[7:0];
  end

  // --------------------------------------------------------------------
  // Channel 2 duty and control registers, run control and channel 2 counter clear
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ch2_duty_high <= pwmps_pkg::DUTY_HIGH_RESET;
    else if (index == pwmps_pkg::IDX_CH2_DUTY_HIGH && low_lane)
      ch2_duty_high <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch2_control_zero <= pwmps_pkg::CONTROL_ZERO_RESET;
      ch2_control_one <= pwmps_pkg::CONTROL_ONE_RESET;
    end
    else if (index == pwmps_pkg::IDX_CH2_CONTROL_ZERO && low_lane)
    begin
      ch2_control_zero <= pwdata[7:0];
      if (high_lane)
        ch2_control_one <= pwdata[15:8];
    end
    else if (index == pwmps_pkg::IDX_CH2_CONTROL_ONE && low_lane)
      ch2_control_one <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_control <= pwmps_pkg::RUN_RESET;
    else if (index == pwmps_pkg::IDX_RUN_CONTROL && low_lane)
      run_control <= pwdata[pwmps_pkg::RUN_WIDTH-1:0];
  end

  // Data ignored, any accepted write to either byte clears
  assign ch2_clear = write_go && (index == pwmps_pkg::IDX_CH2_COUNTER_LOW ||
    index == pwmps_pkg::IDX_CH2_COUNTER_HIGH);

  // --------------------------------------------------------------------
  // Count rate divider
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_count <= 16'h0000;
    else if (tick)
      tick_count <= 16'h0000;
    else
      tick_count <= tick_count + 16'h0001;
  end

  assign tick = (tick_count == 16'(TICK_DIVIDE - 1));

  // --------------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------------
  assign period_value[0] = {ch0_period_high, ch0_period_low};
  assign period_value[1] = {ch1_period_high, ch1_period_low};
  assign period_value[2] = pwmps_pkg::CH2_PERIOD_FULL;
  assign clear = {ch2_clear, 2'b00};

  for (genvar ch = 0; ch < pwmps_pkg::CHANNELS; ch++)
  begin : channel
    // Zero period substitution and buffer compare inside
    pwmps_channel unit
    (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .run(run_control[ch]),
      .clear(clear[ch]),
      .period_value(period_value[ch]),
      .count(count_value[ch]),
      .period_buffer(buffer_value[ch]),
      .period_end(period_end[ch])
    );
  end

  assign ch0_count = count_value[0];
  assign ch1_count = count_value[1];
  assign ch2_count = count_value[2];
  assign ch0_period_buffer = buffer_value[0];
  assign ch1_period_buffer = buffer_value[1];

endmodule

// [verification/pwmps_slice_chk.sv]
// Port assertions for the period register slice
`timescale 1ns/1ps
module pwmps_slice_chk
#(
  parameter int ADDR_WIDTH = 18,
  parameter int TICK_DIVIDE = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] ch0_period_buffer,
  input wire logic [15:0] ch1_period_buffer,
  input wire logic [15:0] ch0_count,
  input wire logic [15:0] ch1_count,
  input wire logic [15:0] ch2_count,
  input wire logic [2:0] period_end,
  input wire logic [7:0] ch2_duty_high,
  input wire logic [7:0] ch2_control_zero,
  input wire logic [7:0] ch2_control_one
);
  logic [15:0] idx;
  logic wr_ok;
  assign idx = paddr[17:2];
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;

  default clocking dclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  setup_then_ready_a:
    assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  error_with_ready_a:
    assert property (pslverr |-> pready)
    else $error("error without ready");
  byte_only_refused_a:
    assert property (psel && penable && pready && pwrite && pstrb == 4'h3
      && idx inside {16'hF0A1, 16'hF0A9, 16'hF0B3, 16'hF0B5, 16'hF0B7}
      |-> pslverr)
    else $error("word write to byte register taken");
  buffer0_nonzero_a:
    assert property (ch0_period_buffer != 16'h0000)
    else $error("channel 0 buffer zero");
  buffer1_nonzero_a:
    assert property (ch1_period_buffer != 16'h0000)
    else $error("channel 1 buffer zero");
  counter_clear_a:
    assert property (wr_ok && pstrb != 4'h0
      && idx inside {16'hF0B4, 16'hF0B5} |=> ch2_count == 16'h0000)
    else $error("counter not cleared");
  control_one_write_a:
    assert property (wr_ok && idx == 16'hF0B7 && pstrb == 4'h1
      |=> ch2_control_one == $past(pwdata[7:0]))
    else $error("control one write lost");
  control_word_write_a:
    assert property (wr_ok && idx == 16'hF0B6 && pstrb == 4'h3
      |=> ch2_control_zero == $past(pwdata[7:0])
      && ch2_control_one == $past(pwdata[15:8]))
    else $error("control word write lost");
  duty_high_write_a:
    assert property (wr_ok && idx == 16'hF0B3 && pstrb == 4'h1
      |=> ch2_duty_high == $past(pwdata[7:0]))
    else $error("duty high write lost");
  reset_values_a:
    assert property ($rose(presetn) |-> ch0_period_buffer == 16'hFFFF
      && ch1_period_buffer == 16'hFFFF && ch2_control_one == 8'h40
      && ch2_control_zero == 8'h00 && ch2_count == 16'h0000)
    else $error("wrong value after reset");

  // ------------------------------------------------------------------
  // Covers
  // ------------------------------------------------------------------
  cover property (wr_ok && idx == 16'hF0B6 && pstrb == 4'h3);
  cover property (psel && penable && pready && pslverr);
  cover property (period_end[0]);
  cover property (wr_ok && idx == 16'hF0B5);
endmodule

bind pwmps_slice pwmps_slice_chk
#(.ADDR_WIDTH(ADDR_WIDTH), .TICK_DIVIDE(TICK_DIVIDE)) u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ch0_period_buffer(ch0_period_buffer),
  .ch1_period_buffer(ch1_period_buffer), .ch0_count(ch0_count),
  .ch1_count(ch1_count), .ch2_count(ch2_count), .period_end(period_end),
  .ch2_duty_high(ch2_duty_high), .ch2_control_zero(ch2_control_zero),
  .ch2_control_one(ch2_control_one)
);

// [verification/pwmps_slice_test.sv]
// Self-checking bench for the period register slice
`timescale 1ns/1ps
module pwmps_slice_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] buf0;
  logic [15:0] buf1;
  logic [15:0] cnt0;
  logic [15:0] cnt1;
  logic [15:0] cnt2;
  logic [7:0] wraps = 8'h00;
  logic [7:0] wraps_before = 8'h00;
  logic [2:0] pend;
  logic [7:0] duty;
  logic [7:0] ctl0;
  logic [7:0] ctl1;
  logic [1:0] off = 2'h0;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] ri [9] = '{16'hF0A0, 16'hF0A1, 16'hF0A8, 16'hF0A9,
    16'hF0B3, 16'hF0B4, 16'hF0B5, 16'hF0B6, 16'hF0B7};
  logic [15:0] rv [9] = '{16'hFFFF, 16'h00FF, 16'hFFFF, 16'h00FF,
    16'h0000, 16'h0000, 16'h0000, 16'h4000, 16'h0040};
  logic [15:0] bo [5] = '{16'hF0A1, 16'hF0A9, 16'hF0B3, 16'hF0B5, 16'hF0B7};

  always #2 pclk = ~pclk;

  pwmps_slice #(.ADDR_WIDTH(18), .TICK_DIVIDE(2)) u_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch0_period_buffer(buf0), .ch1_period_buffer(buf1),
    .ch0_count(cnt0), .ch1_count(cnt1), .ch2_count(cnt2),
    .period_end(pend), .ch2_duty_high(duty),
    .ch2_control_zero(ctl0), .ch2_control_one(ctl1)
  );

  task test_done;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, checks error flag and read data
  task acc(input logic [15:0] i, input logic w, input logic [31:0] d,
    input logic [3:0] s, input logic e, input logic [31:0] x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, off};
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    check({pslverr, prdata}, {e, x});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts period end pulses of channel 1
  always @(posedge pclk)
    if (pend[1] === 1'b1)
      wraps <= wraps + 8'h01;

  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt++;
      test_done;
    end
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 9; k++)
      acc(ri[k], 1'b0, 32'h0, 4'h0, 1'b0, {16'h0, rv[k]});
    settle(0);
    check({1'b0, buf0, buf1}, {1'b0, 32'hFFFFFFFF});
    check({25'h0, ctl1}, 33'h40);
    $display("reset test done");
    acc(16'hF0A0, 1'b1, 32'h1234, 4'h3, 1'b0, 32'h0);
    acc(16'hF0A1, 1'b1, 32'hAB, 4'h1, 1'b0, 32'h0);
    acc(16'hF0A0, 1'b0, 32'h0, 4'h0, 1'b0, 32'hAB34);
    acc(16'hF0A8, 1'b1, 32'hCD, 4'h1, 1'b0, 32'h0);
    acc(16'hF0A9, 1'b1, 32'h56, 4'h1, 1'b0, 32'h0);
    acc(16'hF0A8, 1'b0, 32'h0, 4'h0, 1'b0, 32'h56CD);
    for (int k = 0; k < 5; k++)
      acc(bo[k], 1'b1, 32'h9999, 4'h3, 1'b1, 32'h0);
    acc(16'hF0A9, 1'b0, 32'h0, 4'h0, 1'b0, 32'h56);
    settle(2);
    check({1'b0, buf0, buf1}, {1'b0, 32'hAB3456CD});
    $display("period test done");
    acc(16'hF0A0, 1'b1, 32'h0, 4'h3, 1'b0, 32'h0);
    acc(16'hF0A8, 1'b1, 32'h0, 4'h3, 1'b0, 32'h0);
    settle(2);
    check({1'b0, buf0, buf1}, 33'h000010001);
    acc(16'hF0BF, 1'b1, 32'h3, 4'h1, 1'b0, 32'h0);
    acc(16'hF0BF, 1'b0, 32'h0, 4'h0, 1'b0, 32'h3);
    settle(20);
    check({1'b0, buf0, cnt0}, 33'h000010000);
    acc(16'hF0BF, 1'b1, 32'h0, 4'h1, 1'b0, 32'h0);
    $display("zero period test done");
    acc(16'hF0A8, 1'b1, 32'h20, 4'h3, 1'b0, 32'h0);
    acc(16'hF0BF, 1'b1, 32'h2, 4'h1, 1'b0, 32'h0);
    acc(16'hF0A8, 1'b1, 32'h4, 4'h3, 1'b0, 32'h0);
    settle(0);
    wraps_before = wraps;
    check({17'h0, buf1}, 33'h20);
    settle(40);
    check({17'h0, buf1}, 33'h20);
    check({25'h0, wraps}, {25'h0, wraps_before});
    settle(40);
    check({17'h0, buf1}, 33'h4);
    check({32'h0, cnt1 < 16'h0004}, 33'h1);
    check({32'h0, wraps != wraps_before}, 33'h1);
    acc(16'hF0BF, 1'b1, 32'h0, 4'h1, 1'b0, 32'h0);
    $display("period buffer test done");
    acc(16'hF0B3, 1'b1, 32'h5A, 4'h1, 1'b0, 32'h0);
    acc(16'hF0B6, 1'b1, 32'h1A2B, 4'h3, 1'b0, 32'h0);
    acc(16'hF0B7, 1'b0, 32'h0, 4'h0, 1'b0, 32'h1A);
    acc(16'hF0B7, 1'b1, 32'h7F, 4'h1, 1'b0, 32'h0);
    acc(16'hF0B6, 1'b0, 32'h0, 4'h0, 1'b0, 32'h7F2B);
    acc(16'hF0B3, 1'b0, 32'h0, 4'h0, 1'b0, 32'h5A);
    settle(0);
    check({9'h0, duty, ctl0, ctl1}, 33'h5A2B7F);
    for (int k = 0; k < 2; k++)
    begin
      acc(16'hF0BF, 1'b1, 32'h4, 4'h1, 1'b0, 32'h0);
      settle(30);
      acc(16'hF0BF, 1'b1, 32'h0, 4'h1, 1'b0, 32'h0);
      settle(0);
      check({32'h0, cnt2 != 16'h0}, 33'h1);
      acc(16'(16'hF0B5 - k), 1'b1, 32'hFF, 4'(1 + 2 * k), 1'b0,
        32'h0);
      acc(16'hF0B4, 1'b0, 32'h0, 4'h0, 1'b0, 32'h0);
    end
    $display("channel two test done");
    acc(16'hF0C0, 1'b0, 32'h0, 4'h0, 1'b1, 32'h0);
    off = 2'h2;
    acc(16'hF0A0, 1'b0, 32'h0, 4'h0, 1'b1, 32'h0);
    off = 2'h0;
    acc(16'hF0B6, 1'b1, 32'h1, 4'hF, 1'b1, 32'h0);
    acc(16'hF0B6, 1'b0, 32'h0, 4'h0, 1'b0, 32'h7F2B);
    $display("refusal test done");
    test_done;
  end
endmodule
